// ===== host_irq_port_select_verify.sv
/*
 * Interrupt flags and masks with two active-low lines, host serial port
 * choice by select-pin edge counting with lock, and last-access record.
 * Assumes protocol engines on clk present one access per valid cycle and
 * flag events as one-cycle pulses on clk; the select pin is asynchronous.
 */
// Functional notes
// - Two interrupt lines, each gated by its own 32-bit enable mask.
// - Events set their flag whatever the mask holds.
// - A line is low while any flag and its mask bit are both one.
// - Writing ones clears flags; line stays low until enabled flags clear.
// - Both masks are zero after reset.
// - Reset end sets bit 15 of second flags; second line low, unmaskable.
// - Second-mask bits 0-2, 16-18, 23-24 pair with per-phase registers.
// - First-mask bits 6-13 and 18 pair with the power direction register.
// - Capture port off after reset; select pin high keeps two-wire port.
// - Three falling select edges choose four-wire port until normal-mode reset or power-down.
// - Lock bit in two-wire mode makes select toggling ignored.
// - In four-wire mode any second setup write locks the choice.
// - Lock survives power modes; cleared by normal-mode reset or power-down.
// - Successful access stores its 16-bit address until the next one.
// - Successful access records kind: write or read code.
// - Last access data readable at one of three width addresses.
// - Unsuccessful accesses leave the record unchanged.
// - Reading the record registers does not update the record.
// - Two-wire device address is first byte's top seven bits, bit 0 read.
`timescale 1ns/1ps
module host_irq_port_select_verify
    import irq_port_pkg::*;
#(
    parameter int FLAG_WIDTH = 32
)
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  normal_power_state,
    input  wire logic                  power_down,
    input  wire logic                  soft_reset,
    // Events
    input  wire logic [FLAG_WIDTH-1:0] event_a,
    input  wire logic [FLAG_WIDTH-1:0] event_b,
    // Register access
    input  wire access_type            access,
    output logic [31:0]                read_data,
    // Two-wire address byte
    input  wire addr_byte_type         addr_byte,
    output logic                       addr_hit,
    output logic                       addr_read,
    // Select pin and port choice
    input  wire logic                  select_or_capture_ack_pin,
    output logic                       four_wire_active,
    output logic                       fast_capture_port_en,
    output logic                       port_locked,
    // Interrupt lines
    output logic                       int_line_a_b,
    output logic                       int_line_b_b
);

    typedef struct packed {
        logic [FLAG_WIDTH-1:0] enable_mask_a;
        logic [FLAG_WIDTH-1:0] enable_mask_b;
        logic [FLAG_WIDTH-1:0] event_flags_a;
        logic [FLAG_WIDTH-1:0] event_flags_b;
        logic [7:0]            setup;
        logic                  rst_pend;
        logic                  sel_s1;
        logic                  sel_s2;
        logic                  sel_s3;
        logic [1:0]            falls;
        logic                  lock;
        logic                  spi;
        logic                  cap_en;
        logic [15:0]           recent_location;
        logic [7:0]            recent_kind;
        logic [31:0]           recent_value;
        logic [31:0]           rdata;
        logic                  hit;
        logic                  rd_dir;
        logic                  int_a;
        logic                  int_b;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic [FLAG_WIDTH-1:0] rst_mask;
    logic [31:0]           rd_val;
    logic                  is_recent;
    logic                  commit;
    logic                  wr;
    logic                  spi_now;

    assign rst_mask = FLAG_WIDTH'(1) << RESET_FINISHED_BIT;
    assign commit   = access.valid && access.ok;
    assign wr       = access.valid && access.write;
    assign spi_now  = (st_r.falls == SELECT_FALLS);

    // Read multiplexer
    always_comb
    begin
        rd_val = 32'h00000000;
        case (access.addr)
            ADDR_ENABLE_MASK_A:   rd_val = 32'(st_r.enable_mask_a);
            ADDR_ENABLE_MASK_B:   rd_val = 32'(st_r.enable_mask_b);
            ADDR_EVENT_FLAGS_A:   rd_val = 32'(st_r.event_flags_a);
            ADDR_EVENT_FLAGS_B:   rd_val = 32'(st_r.event_flags_b);
            ADDR_SECOND_SETUP:    rd_val = {24'h000000, st_r.setup};
            ADDR_RECENT_LOCATION: rd_val = {16'h0000, st_r.recent_location};
            ADDR_RECENT_KIND:     rd_val = {24'h000000, st_r.recent_kind};
            ADDR_RECENT_VALUE_8:  rd_val = {24'h000000, st_r.recent_value[7:0]};
            ADDR_RECENT_VALUE_16: rd_val = {16'h0000, st_r.recent_value[15:0]};
            ADDR_RECENT_VALUE_32: rd_val = st_r.recent_value;
            default:              rd_val = 32'h00000000;
        endcase
    end

    always_comb
    begin
        is_recent = (access.addr == ADDR_RECENT_LOCATION) ||
                    (access.addr == ADDR_RECENT_KIND) ||
                    (access.addr == ADDR_RECENT_VALUE_8) ||
                    (access.addr == ADDR_RECENT_VALUE_16) ||
                    (access.addr == ADDR_RECENT_VALUE_32);
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rst_pend = 1'b0;
        st_nxt.rdata = rd_val;

        // Masks and setup
        if (wr && access.addr == ADDR_ENABLE_MASK_A)
            st_nxt.enable_mask_a = access.data[FLAG_WIDTH-1:0];
        if (wr && access.addr == ADDR_ENABLE_MASK_B)
            st_nxt.enable_mask_b = access.data[FLAG_WIDTH-1:0];
        if (wr && access.addr == ADDR_SECOND_SETUP)
        begin
            st_nxt.setup = access.data[7:0];
            if (spi_now || access.data[LOCK_BIT])
                st_nxt.lock = 1'b1;
        end

        // Flags: write-one clears, an event in the same cycle wins
        st_nxt.event_flags_a = st_r.event_flags_a;
        st_nxt.event_flags_b = st_r.event_flags_b;
        if (wr && access.addr == ADDR_EVENT_FLAGS_A)
            st_nxt.event_flags_a = st_r.event_flags_a &
                                   ~access.data[FLAG_WIDTH-1:0];
        if (wr && access.addr == ADDR_EVENT_FLAGS_B)
            st_nxt.event_flags_b = st_r.event_flags_b &
                                   ~access.data[FLAG_WIDTH-1:0];
        st_nxt.event_flags_a = st_nxt.event_flags_a | event_a;
        st_nxt.event_flags_b = st_nxt.event_flags_b | event_b;
        if (st_r.rst_pend)
            st_nxt.event_flags_b = st_nxt.event_flags_b | rst_mask;

        // Select pin edge counting
        st_nxt.sel_s1 = select_or_capture_ack_pin;
        st_nxt.sel_s2 = st_r.sel_s1;
        st_nxt.sel_s3 = st_r.sel_s2;
        if (st_r.sel_s3 && !st_r.sel_s2 && !st_r.lock && !spi_now)
            st_nxt.falls = st_r.falls + 2'h1;

        // Access record
        if (commit && !(is_recent && !access.write))
        begin
            st_nxt.recent_location = access.addr;
            st_nxt.recent_kind = access.write ? KIND_WRITE : KIND_READ;
            st_nxt.recent_value = access.write ? access.data : rd_val;
        end

        // Two-wire address byte
        if (addr_byte.valid)
        begin
            st_nxt.hit = (addr_byte.value[7:1] == TWO_WIRE_DEV_ADDR);
            st_nxt.rd_dir = addr_byte.value[0];
        end

        // Soft reset returns interrupt state to defaults
        if (soft_reset)
        begin
            st_nxt.enable_mask_a = MASK_RESET;
            st_nxt.enable_mask_b = MASK_RESET;
            st_nxt.event_flags_a = FLAGS_RESET;
            st_nxt.event_flags_b = FLAGS_RESET;
            st_nxt.rst_pend = 1'b1;
        end

        // Port choice and lock cleared here by power-down
        if (power_down)
        begin
            st_nxt.falls = 2'h0;
            st_nxt.lock = 1'b0;
        end

        // Port outputs follow the next choice and setup
        st_nxt.spi    = (st_nxt.falls == SELECT_FALLS);
        st_nxt.cap_en = st_nxt.setup[0] & ~st_nxt.spi;

        // Lines follow the next flag and mask values
        st_nxt.int_a = ~|(st_nxt.event_flags_a &
                          st_nxt.enable_mask_a);
        st_nxt.int_b = ~|(st_nxt.event_flags_b &
                          (st_nxt.enable_mask_b | rst_mask));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_r.enable_mask_a   <= MASK_RESET;
            st_r.enable_mask_b   <= MASK_RESET;
            st_r.event_flags_a   <= FLAGS_RESET;
            st_r.event_flags_b   <= FLAGS_RESET;
            st_r.setup           <= SETUP_RESET;
            st_r.rst_pend        <= 1'b1;
            st_r.rdata           <= 32'h00000000;
            st_r.hit             <= 1'b0;
            st_r.rd_dir          <= 1'b0;
            st_r.int_a           <= 1'b1;
            st_r.int_b           <= 1'b1;
            st_r.recent_location <= 16'h0000;
            st_r.recent_kind     <= 8'h00;
            st_r.recent_value    <= 32'h00000000;
            st_r.sel_s1          <= 1'b1;
            st_r.sel_s2          <= 1'b1;
            st_r.sel_s3          <= 1'b1;
            st_r.cap_en          <= 1'b0;
            if (normal_power_state || power_down)
            begin
                st_r.spi   <= 1'b0;
                st_r.falls <= 2'h0;
                st_r.lock  <= 1'b0;
            end
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign read_data            = st_r.rdata;
    assign addr_hit             = st_r.hit;
    assign addr_read            = st_r.rd_dir;
    assign four_wire_active     = st_r.spi;
    assign fast_capture_port_en = st_r.cap_en;
    assign port_locked          = st_r.lock;
    assign int_line_a_b         = st_r.int_a;
    assign int_line_b_b         = st_r.int_b;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_reset_end;
        $rose(rst_b);
    endsequence

    sequence s_reset_flag_shown;
        st_r.event_flags_b[RESET_FINISHED_BIT] && !int_line_b_b;
    endsequence

    property p_mask_reset;
        s_reset_end |-> st_r.enable_mask_a == MASK_RESET &&
                        st_r.enable_mask_b == MASK_RESET;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("masks not clear after reset");

    property p_flag_set;
        (|event_a) && !soft_reset |=>
            (st_r.event_flags_a & $past(event_a)) == $past(event_a);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");

    property p_line_a;
        wr && access.addr == ADDR_ENABLE_MASK_A && !soft_reset &&
            |(st_r.event_flags_a & access.data[FLAG_WIDTH-1:0]) |=>
            !int_line_a_b;
    endproperty
    a_line_a: assert property (p_line_a)
        else $error("first line disagrees with flags and mask");

    property p_clear;
        wr && access.addr == ADDR_EVENT_FLAGS_A && !soft_reset |=>
            (st_r.event_flags_a & $past(access.data) & ~$past(event_a)) == 0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("written flag not cleared");

    property p_reset_done;
        s_reset_end ##1 !soft_reset |-> s_reset_flag_shown;
    endproperty
    a_reset_done: assert property (p_reset_done)
        else $error("reset finished flag missing");

    property p_saturate;
        four_wire_active && !power_down |=> four_wire_active;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("port choice lost without reset");

    property p_lock_hold;
        st_r.lock && !power_down |=> $stable(st_r.falls) && st_r.lock;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked choice changed");

    property p_kind;
        commit && access.write |=> st_r.recent_kind == KIND_WRITE &&
            st_r.recent_location == $past(access.addr);
    endproperty
    a_kind: assert property (p_kind)
        else $error("write not recorded");

    property p_fail_hold;
        !commit |=> $stable(st_r.recent_location) &&
                    $stable(st_r.recent_value);
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("record changed without a successful access");

    property p_self_read;
        commit && !access.write && is_recent |=>
            $stable(st_r.recent_kind) && $stable(st_r.recent_location);
    endproperty
    a_self_read: assert property (p_self_read)
        else $error("record read updated the record");

endmodule

// ===== irq_port_pkg.sv
/*
 * Constants and carrier types for the host-facing interrupt, serial port
 * selection and access-record logic.
 * Assumes a 16-bit register address space and 32-bit register data.
 */
package irq_port_pkg;

    // Register locations
    localparam logic [15:0] ADDR_RECENT_VALUE_32 = 16'hE5FF;
    localparam logic [15:0] ADDR_RECENT_VALUE_8  = 16'hE7FD;
    localparam logic [15:0] ADDR_RECENT_LOCATION = 16'hE9FE;
    localparam logic [15:0] ADDR_RECENT_VALUE_16 = 16'hE9FF;
    localparam logic [15:0] ADDR_RECENT_KIND     = 16'hEA01;
    localparam logic [15:0] ADDR_ENABLE_MASK_A   = 16'hEC00;
    localparam logic [15:0] ADDR_ENABLE_MASK_B   = 16'hEC04;
    localparam logic [15:0] ADDR_EVENT_FLAGS_A   = 16'hEC08;
    localparam logic [15:0] ADDR_EVENT_FLAGS_B   = 16'hEC0C;
    localparam logic [15:0] ADDR_SECOND_SETUP    = 16'hEC10;

    // Field positions and values
    localparam int          RESET_FINISHED_BIT = 15;
    localparam int          LOCK_BIT           = 1;
    localparam logic [7:0]  KIND_WRITE         = 8'hCA;
    localparam logic [7:0]  KIND_READ          = 8'h35;
    localparam logic [1:0]  SELECT_FALLS       = 2'h3;
    localparam logic [6:0]  TWO_WIRE_DEV_ADDR  = 7'h38;
    localparam logic [31:0] MASK_RESET         = 32'h00000000;
    localparam logic [31:0] FLAGS_RESET        = 32'h00000000;
    localparam logic [7:0]  SETUP_RESET        = 8'h00;

    typedef enum logic [1:0] {
        SIZE_8  = 2'b00,
        SIZE_16 = 2'b01,
        SIZE_32 = 2'b10
    } size_type;

    // One register access from a protocol engine
    typedef struct packed {
        logic        valid;
        logic        ok;
        logic        write;
        size_type    size;
        logic [15:0] addr;
        logic [31:0] data;
    } access_type;

    // First byte of a two-wire transfer
    typedef struct packed {
        logic       valid;
        logic [7:0] value;
    } addr_byte_type;

endpackage

// ===== host_mcu_model.sv
/*
 * Host microcontroller model: drives the select pin and tallies
 * falling edges on both interrupt lines as edge-triggered inputs.
 * Assumes the device lines are active low and idle high.
 */
`timescale 1ns/1ps
module host_mcu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Interrupt lines
    input  wire logic       int_line_a_b,
    input  wire logic       int_line_b_b,
    // Select pin and edge tallies
    output logic            select_pin,
    output logic [7:0]      falls_a,
    output logic [7:0]      falls_b
);
    logic prev_a = 1'b1;
    logic prev_b = 1'b1;

    initial
    begin
        select_pin = 1'b1;
        falls_a = 8'h00;
        falls_b = 8'h00;
    end

    // Negative-edge interrupt detection
    always @(posedge clk)
    begin
        if (rst_b && prev_a && !int_line_a_b)
            falls_a <= falls_a + 8'h01;
        if (rst_b && prev_b && !int_line_b_b)
            falls_b <= falls_b + 8'h01;
        prev_a <= int_line_a_b;
        prev_b <= int_line_b_b;
    end

    // Toggle the select pin as a general output
    task automatic toggle_select(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1 select_pin = 1'b0;
            repeat (4) @(posedge clk);
            #1 select_pin = 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

// ===== tb_top.sv
/*
 * Testbench: register accesses, interrupt service, record and port choice.
 * Assumes the design and the host model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_top
    import irq_port_pkg::*;
();
    logic          clk, rst_b, normal_power_state, power_down, soft_reset;
    logic [31:0]   event_a, event_b, read_data, rd;
    access_type    access;
    addr_byte_type addr_byte;
    logic          addr_hit, addr_read, sel_pin, four_wire_active;
    logic          fast_capture_port_en, port_locked;
    logic          int_line_a_b, int_line_b_b;
    logic [7:0]    falls_a, falls_b;
    int            num_errors = 0;
    int            checks_done = 0;
    int            bits_a[9] = '{6, 7, 8, 9, 10, 11, 12, 13, 18};
    int            bits_b[8] = '{0, 1, 2, 16, 17, 18, 23, 24};
    logic [7:0]    bytes[4] = '{8'h70, 8'h71, 8'h72, 8'hF0};
    logic [1:0]    hits[4] = '{2'h2, 2'h3, 2'h0, 2'h0};

    host_irq_port_select_verify host_irq_port_select_verify_inst (
        .clk(clk), .rst_b(rst_b), .normal_power_state(normal_power_state),
        .power_down(power_down), .soft_reset(soft_reset),
        .event_a(event_a), .event_b(event_b), .access(access),
        .read_data(read_data), .addr_byte(addr_byte), .addr_hit(addr_hit),
        .addr_read(addr_read), .select_or_capture_ack_pin(sel_pin),
        .four_wire_active(four_wire_active),
        .fast_capture_port_en(fast_capture_port_en),
        .port_locked(port_locked), .int_line_a_b(int_line_a_b),
        .int_line_b_b(int_line_b_b));

    host_mcu_model host_mcu_model_inst (
        .clk(clk), .rst_b(rst_b), .int_line_a_b(int_line_a_b),
        .int_line_b_b(int_line_b_b), .select_pin(sel_pin),
        .falls_a(falls_a), .falls_b(falls_b));

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic acc(input logic w, ok, input logic [15:0] a,
                       input logic [31:0] d, input size_type s);
        @(posedge clk);
        #1 access = {1'b1, ok, w, s, a, d};
        @(posedge clk);
        #1 rd = read_data;
        access.valid = 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        acc(1'b1, 1'b1, a, d, SIZE_32);
    endtask

    task automatic chk_rd(input logic [15:0] a, input logic [31:0] exp);
        acc(1'b0, 1'b1, a, 32'h0, SIZE_32);
        `CHK(rd, exp)
    endtask

    task automatic hw_reset(input logic np, input int n);
        @(posedge clk);
        #1 normal_power_state = np;
        rst_b = 1'b0;
        repeat (n) @(posedge clk);
        #1 rst_b = 1'b1;
        idle(3);
    endtask

    // Event, masked check, enable, zero write and full clear
    task automatic irq_step(input logic sel, input int b);
        logic [15:0] ma, fa;
        logic [31:0] v;
        ma = sel ? ADDR_ENABLE_MASK_B : ADDR_ENABLE_MASK_A;
        fa = sel ? ADDR_EVENT_FLAGS_B : ADDR_EVENT_FLAGS_A;
        v = 32'h1 << b;
        wr(ma, 32'h0);
        @(posedge clk);
        #1 if (sel) event_b = v; else event_a = v;
        @(posedge clk);
        #1 event_a = 32'h0;
        event_b = 32'h0;
        idle(2);
        `CHK(sel ? int_line_b_b : int_line_a_b, 1'b1)
        chk_rd(fa, v);
        wr(ma, v);
        idle(2);
        `CHK(sel ? int_line_b_b : int_line_a_b, 1'b0)
        wr(fa, 32'h0);
        idle(2);
        `CHK(sel ? int_line_b_b : int_line_a_b, 1'b0)
        wr(fa, v);
        idle(2);
        `CHK(sel ? int_line_b_b : int_line_a_b, 1'b1)
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        rst_b = 1'b0;
        normal_power_state = 1'b1;
        power_down = 1'b0;
        soft_reset = 1'b0;
        event_a = 32'h0;
        event_b = 32'h0;
        access = '0;
        addr_byte = '0;
        hw_reset(1'b1, 15);
        `CHK({four_wire_active, fast_capture_port_en}, 2'h0)
        `CHK({int_line_a_b, int_line_b_b}, 2'h2)
        chk_rd(ADDR_ENABLE_MASK_A, MASK_RESET);
        chk_rd(ADDR_ENABLE_MASK_B, MASK_RESET);
        chk_rd(ADDR_EVENT_FLAGS_B, 32'h00008000);
        chk_rd(ADDR_RECENT_KIND, {24'h0, KIND_READ});
        chk_rd(ADDR_RECENT_LOCATION, 32'h0000EC0C);
        wr(ADDR_EVENT_FLAGS_B, 32'h00008000);
        idle(2);
        `CHK(int_line_b_b, 1'b1)
        foreach (bits_a[i]) irq_step(1'b0, bits_a[i]);
        foreach (bits_b[i]) irq_step(1'b1, bits_b[i]);
        `CHK({falls_a, falls_b}, 16'h0909)
        wr(ADDR_ENABLE_MASK_B, 32'h12345678);
        chk_rd(ADDR_RECENT_LOCATION, 32'h0000EC04);
        chk_rd(ADDR_RECENT_KIND, {24'h0, KIND_WRITE});
        chk_rd(ADDR_RECENT_VALUE_8, 32'h00000078);
        chk_rd(ADDR_RECENT_VALUE_16, 32'h00005678);
        chk_rd(ADDR_RECENT_VALUE_32, 32'h12345678);
        acc(1'b0, 1'b0, ADDR_ENABLE_MASK_A, 32'h0, SIZE_32);
        chk_rd(ADDR_RECENT_LOCATION, 32'h0000EC04);
        @(posedge clk);
        #1 soft_reset = 1'b1;
        @(posedge clk);
        #1 soft_reset = 1'b0;
        idle(2);
        chk_rd(ADDR_ENABLE_MASK_B, MASK_RESET);
        `CHK(int_line_b_b, 1'b0)
        wr(ADDR_EVENT_FLAGS_B, 32'h00008000);
        foreach (bytes[i])
        begin
            @(posedge clk);
            #1 addr_byte = {1'b1, bytes[i]};
            @(posedge clk);
            #1 addr_byte.valid = 1'b0;
            `CHK({addr_hit, addr_read}, hits[i])
        end
        host_mcu_model_inst.toggle_select(3);
        idle(4);
        `CHK(four_wire_active, 1'b1)
        wr(ADDR_SECOND_SETUP, 32'h0);
        idle(1);
        `CHK(port_locked, 1'b1)
        hw_reset(1'b0, 2);
        `CHK({port_locked, four_wire_active}, 2'h3)
        hw_reset(1'b1, 2);
        `CHK({port_locked, four_wire_active}, 2'h0)
        wr(ADDR_SECOND_SETUP, 32'h3);
        idle(1);
        `CHK({port_locked, fast_capture_port_en}, 2'h3)
        host_mcu_model_inst.toggle_select(3);
        idle(4);
        `CHK(four_wire_active, 1'b0)
        @(posedge clk);
        #1 power_down = 1'b1;
        @(posedge clk);
        #1 power_down = 1'b0;
        idle(2);
        `CHK(port_locked, 1'b0)
        wrap_up();
    end
endmodule
